// [hw/mtc_cmd_decoder.sv]
// Remote command interpreter of an RF level meter: trigger, averaging,
// service request, error and correction-factor commands.
// Assumes bus bytes arrive already handshaken as strobes on clock_i.
//
// Overview of operation
// R1: Continuous mode runs measurement cycles back to back, loading each result.
// R2: Triggered-mode command stops cycling; measuring waits for triggers.
// R3: Immediate trigger in triggered mode takes one measurement, loads result.
// R4: Delayed trigger waits the trigger-delay store time, then measures once.
// R5: A range change adds three seconds after the next trigger.
// R6: Controller sends triggered mode, one trigger, then GET per cycle.
// R7: GET in continuous mode aborts the cycle and restarts at once.
// R8: Continuous averaging forces continuous running; cancel restores last mode.
// R9: Two averaging codes pick fixed or continuous averaging.
// R10: Store commands copy numeric entry into averaging or delay store.
// R11: Readback commands load averaging or delay store into output buffer.
// R12: After readback, results are held off until the buffer is read.
// R13: Service request policy: never, on data, on error, or either.
// R14: Error readback loads the error number, leaving the error pending.
// R15: Error clear clears errors except the sticky error number one.
// R16: Two calibrate codes disable or enable the user correction factor.
// R17: Measure-correction command measures and saves the user correction.
// R18: Readback codes load user correction or noise store into buffer.
// R19: Codes enable timed auto-calibration, start one now, or inhibit it.
// R20: Correction commands act on the head selected at execution.
// R21: Poll status byte: busy bit 3, error bit 4, request bit 5.
// R22: After reset, service is requested on data or error.
// R23: Every output value is sent as twelve ASCII characters.
// R24: Commands are a letter then a digit; unknown codes change nothing.
`timescale 1ns/10ps
module mtc_cmd_decoder #(
    parameter int unsigned SEC_CYCLES = mtc_pkg::SEC_CYCLES
) (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic [7:0] rx_byte_i,
    input wire logic rx_valid_i,
    input wire logic get_i,
    input wire logic range_chg_i,
    input wire logic head_sel_i,
    input wire logic [mtc_pkg::VAL_W-1:0] num_buf_i,
    input wire logic meas_done_i,
    input wire logic [mtc_pkg::VAL_W-1:0] meas_value_i,
    input wire logic cal_done_i,
    input wire logic [mtc_pkg::VAL_W-1:0] cal_value_i,
    input wire logic [mtc_pkg::VAL_W-1:0] noise_value_i,
    input wire logic err_set_i,
    input wire logic [7:0] err_code_i,
    input wire logic talk_rd_i,
    output logic meas_start_o,
    output logic meas_abort_o,
    output logic cal_meas_o,
    output logic cal_head_o,
    output logic auto_zero_calibration_now_o,
    output logic auto_zero_calibration_timed_o,
    output logic [1:0] ucf_en_o,
    output logic avg_cont_o,
    output logic trig_mode_o,
    output logic srq_o,
    output logic err_pending_o,
    output logic [7:0] status_o,
    output logic [7:0] tx_char_o,
    output logic tx_valid_o
);
    localparam int VW = mtc_pkg::VAL_W;

    // Command decode
    logic [7:0] letter, next_letter;
    logic is_digit, exec;
    logic [7:0] hit_t, hit_s, hit_i, hit_k;
    logic hit_c2;

    always_comb begin
        is_digit = rx_byte_i >= mtc_pkg::ASC_ZERO && rx_byte_i <= mtc_pkg::ASC_NINE;
        exec = rx_valid_i && is_digit && letter != mtc_pkg::NO_LETTER; // see R24
        next_letter = letter;
        if (rx_valid_i) begin
            next_letter = is_digit ? mtc_pkg::NO_LETTER : rx_byte_i;
        end
        // Digits 8 and 9 shift out and hit nothing
        hit_t = (exec && letter == mtc_pkg::CMD_TRIG) ? 8'h01 << rx_byte_i[3:0] : 8'h00;
        hit_s = (exec && letter == mtc_pkg::CMD_AVG) ? 8'h01 << rx_byte_i[3:0] : 8'h00;
        hit_i = (exec && letter == mtc_pkg::CMD_SRQ) ? 8'h01 << rx_byte_i[3:0] : 8'h00;
        hit_k = (exec && letter == mtc_pkg::CMD_CAL) ? 8'h01 << rx_byte_i[3:0] : 8'h00;
        hit_c2 = exec && letter == mtc_pkg::CMD_CANCEL
                 && rx_byte_i[3:0] == 4'(mtc_pkg::DIG_CLR_ERR); // see R15
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            letter <= mtc_pkg::NO_LETTER;
        end else begin
            letter <= next_letter;
        end
    end

    // Modes and stores
    logic trig_sel, next_trig_sel, next_avg_cont;
    logic [VW-1:0] avg_store, next_avg_store, dly_store, next_dly_store;
    logic [1:0] srq_mode, next_srq_mode;
    logic next_err_pending;
    logic [7:0] err_num, next_err_num;
    logic [1:0] next_ucf_en;
    logic [VW-1:0] ucf_store [2];
    logic [VW-1:0] next_ucf_store [2];
    logic next_auto_zero_calibration_timed, next_cal_meas, next_cal_head, next_auto_zero_calibration_now, cal_busy, next_cal_busy;

    always_comb begin
        next_trig_sel = trig_sel;
        next_avg_cont = avg_cont_o;
        next_avg_store = avg_store;
        next_dly_store = dly_store;
        next_srq_mode = srq_mode;
        next_err_pending = err_pending_o;
        next_err_num = err_num;
        next_ucf_en = ucf_en_o;
        next_ucf_store = ucf_store;
        next_auto_zero_calibration_timed = auto_zero_calibration_timed_o;
        next_cal_head = cal_head_o;
        next_cal_busy = cal_busy;
        next_cal_meas = 1'b0;
        next_auto_zero_calibration_now = 1'b0;
        if (hit_t[0]) next_trig_sel = 1'b0; // see R1
        if (hit_t[1]) next_trig_sel = 1'b1; // see R2
        if (hit_s[0]) next_avg_cont = 1'b0; // see R9
        if (hit_s[1]) next_avg_cont = 1'b1; // see R9
        if (hit_s[2]) next_avg_store = num_buf_i; // see R10
        if (hit_s[4]) next_dly_store = num_buf_i; // see R10
        if (|hit_i[3:0]) next_srq_mode = rx_byte_i[1:0]; // see R13
        if (hit_c2 && err_num != mtc_pkg::ERR_STICKY) next_err_pending = 1'b0; // see R15
        // A new error outranks a clear in the same cycle
        if (err_set_i) begin
            next_err_pending = 1'b1;
            next_err_num = err_code_i;
        end
        if (hit_k[0]) next_ucf_en[head_sel_i] = 1'b0; // see R16
        if (hit_k[1]) next_ucf_en[head_sel_i] = 1'b1; // see R16 R20
        if (hit_k[2] && !cal_busy) begin // see R17 R20
            next_cal_meas = 1'b1;
            next_cal_head = head_sel_i;
            next_cal_busy = 1'b1;
        end
        if (cal_done_i && cal_busy) begin // see R17
            next_ucf_store[cal_head_o] = cal_value_i;
            next_cal_busy = 1'b0;
        end
        if (hit_k[5]) next_auto_zero_calibration_timed = 1'b1; // see R19
        if (hit_k[7]) next_auto_zero_calibration_timed = 1'b0; // see R19
        if (hit_k[6]) next_auto_zero_calibration_now = 1'b1; // see R19
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            trig_sel <= 1'b0;
            avg_cont_o <= 1'b0;
            avg_store <= '0;
            dly_store <= '0;
            srq_mode <= mtc_pkg::SRQ_RESET; // see R22
            err_pending_o <= 1'b0;
            err_num <= 8'h00;
            ucf_en_o <= 2'h0;
            ucf_store <= '{default: '0};
            auto_zero_calibration_timed_o <= 1'b0;
            cal_head_o <= 1'b0;
            cal_busy <= 1'b0;
            cal_meas_o <= 1'b0;
            auto_zero_calibration_now_o <= 1'b0;
        end else begin
            trig_sel <= next_trig_sel;
            avg_cont_o <= next_avg_cont;
            avg_store <= next_avg_store;
            dly_store <= next_dly_store;
            srq_mode <= next_srq_mode;
            err_pending_o <= next_err_pending;
            err_num <= next_err_num;
            ucf_en_o <= next_ucf_en;
            ucf_store <= next_ucf_store;
            auto_zero_calibration_timed_o <= next_auto_zero_calibration_timed;
            cal_head_o <= next_cal_head;
            cal_busy <= next_cal_busy;
            cal_meas_o <= next_cal_meas;
            auto_zero_calibration_now_o <= next_auto_zero_calibration_now;
        end
    end

    // Measurement sequencer
    function automatic logic [mtc_pkg::SEC_W-1:0] bcd_secs(input logic [VW-1:0] v);
        logic [15:0] m;
        m = v[mtc_pkg::VAL_MANT_LSB +: 16];
        return mtc_pkg::SEC_W'(m[15:12] * 1000 + m[11:8] * 100 + m[7:4] * 10 + m[3:0]);
    endfunction

    mtc_pkg::mtc_meas_e state, next_state;
    logic [mtc_pkg::DIV_W-1:0] div, next_div;
    logic [mtc_pkg::SEC_W-1:0] secs, next_secs, wait_s;
    logic range_flag, next_range_flag, cont_eff, trig_req, tick, result_ok;
    logic next_start, next_abort;

    always_comb begin
        cont_eff = !trig_sel || avg_cont_o; // see R8
        trig_req = !cont_eff && state == mtc_pkg::MS_IDLE
                   && (hit_t[2] || hit_t[3] || get_i); // see R3 R4 R6
        wait_s = (hit_t[3] ? bcd_secs(dly_store) : '0)
                 + (range_flag ? mtc_pkg::SEC_W'(mtc_pkg::RANGE_SETTLE_S) : '0); // see R4 R5
        tick = div == mtc_pkg::DIV_W'(SEC_CYCLES - 1);
        result_ok = 1'b0;
        next_state = state;
        next_div = div;
        next_secs = secs;
        next_range_flag = range_flag || range_chg_i;
        next_start = 1'b0;
        next_abort = 1'b0;
        unique case (state)
            mtc_pkg::MS_IDLE: begin
                if (cont_eff) begin // see R1
                    next_state = mtc_pkg::MS_RUN;
                    next_start = 1'b1;
                end else if (trig_req) begin
                    next_range_flag = range_chg_i;
                    if (wait_s == '0) begin // see R3
                        next_state = mtc_pkg::MS_RUN;
                        next_start = 1'b1;
                    end else begin
                        next_state = mtc_pkg::MS_DELAY;
                        next_secs = wait_s;
                        next_div = '0;
                    end
                end
            end
            mtc_pkg::MS_DELAY: begin
                next_div = tick ? '0 : div + 1'b1;
                if (tick) begin // see R4 R5
                    next_secs = secs - 1'b1;
                    if (secs == mtc_pkg::SEC_W'(1)) begin
                        next_state = mtc_pkg::MS_RUN;
                        next_start = 1'b1;
                    end
                end
            end
            mtc_pkg::MS_RUN: begin
                if (get_i && cont_eff) begin // see R7
                    next_abort = 1'b1;
                    next_start = 1'b1;
                end else if (meas_done_i) begin
                    result_ok = 1'b1;
                    next_state = mtc_pkg::MS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= mtc_pkg::MS_IDLE;
            div <= '0;
            secs <= '0;
            range_flag <= 1'b0;
            meas_start_o <= 1'b0;
            meas_abort_o <= 1'b0;
        end else begin
            state <= next_state;
            div <= next_div;
            secs <= next_secs;
            range_flag <= next_range_flag;
            meas_start_o <= next_start;
            meas_abort_o <= next_abort;
        end
    end

    // Output buffer
    logic lock, next_lock, avail, next_avail, ob_load, rb_load, fmt_done, next_srq;
    logic [VW-1:0] ob_val;

    always_comb begin
        rb_load = hit_s[3] || hit_s[5] || hit_i[4] || hit_k[3] || hit_k[4]; // see R11 R14 R18
        ob_val = meas_value_i;
        if (hit_s[3]) ob_val = avg_store; // see R11
        if (hit_s[5]) ob_val = dly_store; // see R11
        if (hit_i[4]) ob_val = {1'b0, 8'h00, err_num, 1'b0, 8'h00}; // see R14
        if (hit_k[3]) ob_val = ucf_store[head_sel_i]; // see R18 R20
        if (hit_k[4]) ob_val = noise_value_i; // see R18 R20
        // Held-off results are dropped, not queued
        ob_load = rb_load || (result_ok && !lock); // see R12
        next_lock = rb_load || (lock && !fmt_done); // see R12
        next_avail = (result_ok && !lock) || (avail && !fmt_done && !rb_load);
        next_srq = (srq_mode[mtc_pkg::SRQ_ON_DATA] && next_avail)
                   || (srq_mode[mtc_pkg::SRQ_ON_ERR] && next_err_pending); // see R13
        trig_mode_o = !cont_eff;
        status_o = 8'h00;
        status_o[mtc_pkg::STS_BUSY] = state != mtc_pkg::MS_IDLE || cal_busy; // see R21
        status_o[mtc_pkg::STS_ERR] = err_pending_o; // see R21
        status_o[mtc_pkg::STS_SRQ] = srq_o; // see R21
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lock <= 1'b0;
            avail <= 1'b0;
            srq_o <= 1'b0;
        end else begin
            lock <= next_lock;
            avail <= next_avail;
            srq_o <= next_srq;
        end
    end

    mtc_fmt u_fmt (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .load_i(ob_load),
        .value_i(ob_val),
        .rd_i(talk_rd_i),
        .char_o(tx_char_o),
        .valid_o(tx_valid_o),
        .done_o(fmt_done)
    );

    // Checks
    a_trig_once: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        trig_req && wait_s == '0 |=> meas_start_o ##1 !meas_start_o) // see R3
        else $error("immediate trigger did not start exactly one cycle");
    a_cont_run: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        state == mtc_pkg::MS_IDLE && cont_eff |=> meas_start_o) // see R1
        else $error("continuous mode did not restart measuring");
    a_get_abort: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        get_i && cont_eff && state == mtc_pkg::MS_RUN |=> meas_abort_o && meas_start_o) // see R7
        else $error("GET in continuous mode did not restart");
    a_delay_wait: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        trig_req && wait_s != '0 |=> !meas_start_o [*2]) // see R4
        else $error("delayed trigger started too early");
    a_settle_add: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        trig_req && range_flag && !hit_t[3] |=> secs == mtc_pkg::SEC_W'(mtc_pkg::RANGE_SETTLE_S)) // see R5
        else $error("range settle wait not loaded");
    a_avg_force: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        avg_cont_o |-> !trig_mode_o) // see R8
        else $error("continuous averaging left triggered mode on");
    a_lock_hold: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        lock && !fmt_done && result_ok && !rb_load |=> lock && !avail) // see R12
        else $error("result entered a locked output buffer");
    a_srq_off: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        srq_mode == 2'h0 |=> !srq_o) // see R13
        else $error("service request raised while inhibited");
    a_err_keep: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        hit_c2 && err_pending_o && err_num == mtc_pkg::ERR_STICKY |=> err_pending_o) // see R15
        else $error("error clear removed the sticky error");
    a_err_read: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        hit_i[4] && err_pending_o |=> err_pending_o && tx_valid_o) // see R14
        else $error("error readback cancelled the error");
    a_ucf_head: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        hit_k[1] |=> ucf_en_o[$past(head_sel_i)]) // see R16 R20
        else $error("correction enable missed the selected head");
    c_delay_trig: cover property (@(posedge clock_i) disable iff (!arst_n_i)
        state == mtc_pkg::MS_DELAY ##1 meas_start_o);
    c_readback: cover property (@(posedge clock_i) disable iff (!arst_n_i)
        rb_load ##[1:20] fmt_done);
    c_cont_abort: cover property (@(posedge clock_i) disable iff (!arst_n_i)
        meas_abort_o);
endmodule // mtc_cmd_decoder

// [hw/mtc_fmt.sv]
// Output buffer serialiser: one value record sent as a 12-character string.
// Assumes rd_i is a one-cycle strobe from the talker side on the same clock.
`timescale 1ns/10ps
module mtc_fmt (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic load_i,
    input wire logic [mtc_pkg::VAL_W-1:0] value_i,
    input wire logic rd_i,
    output logic [7:0] char_o,
    output logic valid_o,
    output logic done_o
);
    logic [mtc_pkg::VAL_W-1:0] val, next_val;
    logic [3:0] idx, next_idx;
    logic [7:0] next_ch;
    logic next_valid, next_done;

    function automatic logic [7:0] fchar(input logic [mtc_pkg::VAL_W-1:0] v,
                                         input logic [3:0] i);
        logic [7:0] c;
        c = mtc_pkg::ASC_ZERO;
        unique case (i)
            4'h0: c = v[mtc_pkg::VAL_MSIGN] ? mtc_pkg::ASC_MINUS : mtc_pkg::ASC_PLUS;
            4'h1: c = mtc_pkg::ASC_ZERO | {4'h0, v[mtc_pkg::VAL_MANT_LSB+12 +: 4]};
            4'h2: c = mtc_pkg::ASC_DOT;
            4'h3: c = mtc_pkg::ASC_ZERO | {4'h0, v[mtc_pkg::VAL_MANT_LSB+8 +: 4]};
            4'h4: c = mtc_pkg::ASC_ZERO | {4'h0, v[mtc_pkg::VAL_MANT_LSB+4 +: 4]};
            4'h5: c = mtc_pkg::ASC_ZERO | {4'h0, v[mtc_pkg::VAL_MANT_LSB +: 4]};
            4'h6: c = mtc_pkg::ASC_EXP;
            4'h7: c = v[mtc_pkg::VAL_ESIGN] ? mtc_pkg::ASC_MINUS : mtc_pkg::ASC_PLUS;
            4'h8: c = mtc_pkg::ASC_ZERO | {4'h0, v[7:4]};
            4'h9: c = mtc_pkg::ASC_ZERO | {4'h0, v[3:0]};
            4'hA: c = mtc_pkg::ASC_CR;
            4'hB: c = mtc_pkg::ASC_LF;
            default: c = mtc_pkg::ASC_ZERO;
        endcase
        return c;
    endfunction

    always_comb begin
        next_val = val;
        next_idx = idx;
        next_ch = char_o;
        next_valid = valid_o;
        next_done = 1'b0;
        // A fresh load restarts the string, even mid-transfer
        if (load_i) begin // see R23
            next_val = value_i;
            next_idx = 4'h0;
            next_ch = fchar(value_i, 4'h0);
            next_valid = 1'b1;
        end else if (rd_i && valid_o) begin
            if (idx == 4'(mtc_pkg::OUT_LEN - 1)) begin
                next_valid = 1'b0;
                next_done = 1'b1;
            end else begin
                next_idx = idx + 4'h1;
                next_ch = fchar(val, idx + 4'h1);
            end
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            val <= '0;
            idx <= 4'h0;
            char_o <= 8'h00;
            valid_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            val <= next_val;
            idx <= next_idx;
            char_o <= next_ch;
            valid_o <= next_valid;
            done_o <= next_done;
        end
    end
endmodule // mtc_fmt

// [hw/mtc_pkg.sv]
// Shared constants and types for the meter command interpreter.
// Assumes a 125 MHz system clock; values travel as packed BCD records.
package mtc_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int SECOND_NS = 1_000_000_000;
    localparam int SEC_CYCLES = SECOND_NS / CLK_PERIOD_NS;
    localparam int RANGE_SETTLE_S = 3;
    localparam int SEC_W = 15;
    localparam int DIV_W = 27;
    // Value record: mantissa sign, four mantissa digits, exponent sign, two digits
    localparam int VAL_W = 26;
    localparam int VAL_MSIGN = 25;
    localparam int VAL_MANT_LSB = 9;
    localparam int VAL_ESIGN = 8;
    localparam int OUT_LEN = 12;
    localparam logic [7:0] ASC_ZERO = 8'h30;
    localparam logic [7:0] ASC_NINE = 8'h39;
    localparam logic [7:0] ASC_PLUS = 8'h2B;
    localparam logic [7:0] ASC_MINUS = 8'h2D;
    localparam logic [7:0] ASC_DOT = 8'h2E;
    localparam logic [7:0] ASC_EXP = 8'h45;
    localparam logic [7:0] ASC_CR = 8'h0D;
    localparam logic [7:0] ASC_LF = 8'h0A;
    localparam logic [7:0] CMD_TRIG = 8'h54;
    localparam logic [7:0] CMD_AVG = 8'h53;
    localparam logic [7:0] CMD_SRQ = 8'h49;
    localparam logic [7:0] CMD_CANCEL = 8'h43;
    localparam logic [7:0] CMD_CAL = 8'h4B;
    localparam logic [7:0] NO_LETTER = 8'h00;
    localparam int DIG_CLR_ERR = 2;
    localparam logic [1:0] SRQ_RESET = 2'h3;
    localparam int SRQ_ON_DATA = 0;
    localparam int SRQ_ON_ERR = 1;
    localparam logic [7:0] ERR_STICKY = 8'h01;
    localparam int STS_BUSY = 3;
    localparam int STS_ERR = 4;
    localparam int STS_SRQ = 5;
    typedef enum logic [1:0] {MS_IDLE, MS_DELAY, MS_RUN} mtc_meas_e;
endpackage

// [tb/mtc_cmd_decoder_tb.sv]
// Self-checking bench for the meter command interpreter.
// Assumes the measurement model on the far side; one second shortened to 10 cycles.
`timescale 1ns/10ps
module mtc_cmd_decoder_tb;
    localparam int SEC = 10;
    localparam logic [25:0] MV = {1'b1, 16'h1234, 1'b1, 8'h05};
    localparam logic [25:0] DV = {1'b0, 16'h0002, 1'b0, 8'h00};
    localparam logic [25:0] EV = {1'b0, 16'h0001, 1'b0, 8'h00};
    localparam logic [25:0] NV = {1'b0, 16'h0987, 1'b1, 8'h12};
    logic clock_i, arst_n_i, rx_valid_i, get_i, range_chg_i, head_sel_i;
    logic meas_done_i, cal_done_i, err_set_i, talk_rd_i;
    logic [7:0] rx_byte_i, err_code_i, lat;
    logic [25:0] num_buf_i, meas_value_i, cal_value_i, noise_value_i;
    logic meas_start_o, meas_abort_o, cal_meas_o, cal_head_o, auto_zero_calibration_now_o, auto_zero_calibration_timed_o;
    logic avg_cont_o, trig_mode_o, srq_o, err_pending_o, tx_valid_o;
    logic [1:0] ucf_en_o;
    logic [7:0] status_o, tx_char_o;
    int bad_count, num_checks, starts, n;
    mtc_cmd_decoder #(.SEC_CYCLES(SEC)) dut (.clock_i, .arst_n_i, .rx_byte_i, .rx_valid_i,
        .get_i, .range_chg_i, .head_sel_i, .num_buf_i, .meas_done_i, .meas_value_i,
        .cal_done_i, .cal_value_i, .noise_value_i, .err_set_i, .err_code_i, .talk_rd_i,
        .meas_start_o, .meas_abort_o, .cal_meas_o, .cal_head_o, .auto_zero_calibration_now_o, .auto_zero_calibration_timed_o,
        .ucf_en_o, .avg_cont_o, .trig_mode_o, .srq_o, .err_pending_o, .status_o,
        .tx_char_o, .tx_valid_o);
    mtc_meas_model far (.clock_i, .arst_n_i, .start_i(meas_start_o), .cal_i(cal_meas_o),
        .lat_i(lat), .done_o(meas_done_i), .cal_done_o(cal_done_i));
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end
    always @(posedge clock_i) if (meas_start_o === 1'b1) starts++;
    task automatic conclude();
        if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(string s, logic [7:0] e, logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    function automatic logic [7:0] ch(logic [25:0] v, int i);
        logic [7:0] t[12];
        t = '{v[25] ? 8'h2D : 8'h2B, {4'h3, v[24:21]}, 8'h2E, {4'h3, v[20:17]},
            {4'h3, v[16:13]}, {4'h3, v[12:9]}, 8'h45, v[8] ? 8'h2D : 8'h2B,
            {4'h3, v[7:4]}, {4'h3, v[3:0]}, 8'h0D, 8'h0A};
        return t[i];
    endfunction
    task automatic send(logic [7:0] b);
        @(posedge clock_i);
        rx_byte_i <= b;
        rx_valid_i <= 1'b1;
        @(posedge clock_i);
        rx_valid_i <= 1'b0;
    endtask
    task automatic cmd(logic [7:0] l, logic [3:0] d);
        send(l);
        send({4'h3, d});
        #1;
    endtask
    // Counts cycles until the next start, giving up after lim
    task automatic wst(int lim);
        int k;
        k = starts;
        n = 0;
        while (starts == k && n < lim) begin
            @(posedge clock_i);
            #1;
            n++;
        end
    endtask
    task automatic wtx();
        int k;
        k = 0;
        while (tx_valid_o !== 1'b1 && k < 300) begin
            @(posedge clock_i);
            #1;
            k++;
        end
    endtask
    task automatic get(logic [25:0] v);
        wtx();
        chk("tx_valid_o", 8'h01, tx_valid_o);
        for (int i = 0; i < 12; i++) begin
            chk("tx_char_o", ch(v, i), tx_char_o);
            @(posedge clock_i);
            talk_rd_i <= 1'b1;
            @(posedge clock_i);
            talk_rd_i <= 1'b0;
            #1;
        end
        chk("tx_valid_o", 8'h00, tx_valid_o);
    endtask
    task automatic err(logic [7:0] c);
        @(posedge clock_i);
        err_set_i <= 1'b1;
        err_code_i <= c;
        @(posedge clock_i);
        err_set_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        #1;
    endtask
    initial begin
        repeat (20000) @(posedge clock_i);
        bad_count++;
        conclude();
    end
    initial begin
        {rx_valid_i, get_i, range_chg_i, head_sel_i, err_set_i, talk_rd_i} = 6'h00;
        {rx_byte_i, err_code_i} = 16'h0000;
        {num_buf_i, meas_value_i, cal_value_i, noise_value_i} = {DV, MV, EV, NV};
        lat = 8'h64;
        arst_n_i = 1'b0;
        repeat (6) @(posedge clock_i);
        arst_n_i <= 1'b1;
        wtx();
        chk("srq_o", 8'h01, srq_o);
        chk("status_o", 8'h01, status_o[5]);
        get(MV);
        @(posedge clock_i);
        #1;
        chk("srq_o", 8'h00, srq_o);
        cmd(8'h54, 4'h1);
        chk("trig_mode_o", 8'h01, trig_mode_o);
        wst(150);
        chk("idle", 8'h01, n == 150);
        // Cycle in flight when triggered mode came still lands
        get(MV);
        lat = 8'h02;
        cmd(8'h54, 4'h2);
        wst(8);
        chk("start", 8'h01, n < 8);
        get(MV);
        @(posedge clock_i);
        get_i <= 1'b1;
        @(posedge clock_i);
        get_i <= 1'b0;
        get(MV);
        cmd(8'h53, 4'h4);
        cmd(8'h53, 4'h5);
        get(DV);
        cmd(8'h54, 4'h3);
        wst(60);
        chk("delay", 8'h01, n >= 2 * SEC && n <= 2 * SEC + 4);
        get(MV);
        @(posedge clock_i);
        range_chg_i <= 1'b1;
        @(posedge clock_i);
        range_chg_i <= 1'b0;
        cmd(8'h54, 4'h3);
        wst(90);
        chk("delay", 8'h01, n >= 5 * SEC && n <= 5 * SEC + 4);
        get(MV);
        cmd(8'h53, 4'h5);
        cmd(8'h54, 4'h2);
        repeat (10) @(posedge clock_i);
        get(DV);
        cmd(8'h49, 4'h0);
        cmd(8'h54, 4'h2);
        wtx();
        chk("srq_o", 8'h00, srq_o);
        cmd(8'h49, 4'h2);
        err(8'h01);
        chk("srq_o", 8'h01, srq_o);
        chk("status_o", 8'h01, status_o[4]);
        cmd(8'h43, 4'h2);
        chk("err_pending_o", 8'h01, err_pending_o);
        cmd(8'h49, 4'h4);
        get(EV);
        chk("err_pending_o", 8'h01, err_pending_o);
        err(8'h07);
        cmd(8'h43, 4'h2);
        chk("err_pending_o", 8'h00, err_pending_o);
        @(posedge clock_i);
        head_sel_i <= 1'b1;
        cmd(8'h4B, 4'h1);
        chk("ucf_en_o", 8'h02, ucf_en_o);
        cmd(8'h4B, 4'h2);
        chk("cal_meas_o", 8'h01, cal_meas_o);
        repeat (3) @(posedge clock_i);
        chk("cal_head_o", 8'h01, cal_head_o);
        cmd(8'h4B, 4'h3);
        get(EV);
        cmd(8'h4B, 4'h4);
        get(NV);
        cmd(8'h5A, 4'h0);
        chk("ucf_en_o", 8'h02, ucf_en_o);
        cmd(8'h4B, 4'h5);
        chk("auto_zero_calibration_timed_o", 8'h01, auto_zero_calibration_timed_o);
        cmd(8'h4B, 4'h6);
        chk("auto_zero_calibration_now_o", 8'h01, auto_zero_calibration_now_o);
        cmd(8'h4B, 4'h7);
        chk("auto_zero_calibration_timed_o", 8'h00, auto_zero_calibration_timed_o);
        lat = 8'h64;
        cmd(8'h53, 4'h1);
        chk("avg_cont_o", 8'h01, avg_cont_o);
        chk("trig_mode_o", 8'h00, trig_mode_o);
        @(posedge clock_i);
        get_i <= 1'b1;
        @(posedge clock_i);
        get_i <= 1'b0;
        #1;
        chk("meas_abort_o", 8'h01, meas_abort_o);
        chk("status_o", 8'h01, status_o[3]);
        cmd(8'h53, 4'h0);
        chk("trig_mode_o", 8'h01, trig_mode_o);
        conclude();
    end
endmodule // mtc_cmd_decoder_tb

// [tb/mtc_meas_model.sv]
// Measurement engine model: one done per start not cut off by a new start, after a latency set by the bench.
// Assumes start and correction requests are one-cycle pulses on clock_i.
`timescale 1ns/10ps
module mtc_meas_model (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic start_i,
    input wire logic cal_i,
    input wire logic [7:0] lat_i,
    output logic done_o,
    output logic cal_done_o
);
    logic busy;
    logic [7:0] cnt;
    // A new start drops the old cycle, so an abort needs no path of its own
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            busy <= 1'b0;
            cnt <= 8'h00;
            done_o <= 1'b0;
            cal_done_o <= 1'b0;
        end else begin
            done_o <= busy && cnt == 8'h00 && !start_i;
            cal_done_o <= cal_i;
            if (start_i) begin
                busy <= 1'b1;
                cnt <= lat_i;
            end else if (busy) begin
                busy <= cnt != 8'h00;
                cnt <= cnt - 8'h01;
            end
        end
    end
endmodule // mtc_meas_model
